// ### core/ctsa_consts.svh
// constants for the trigger select and activation block
// Notes on behaviour
// [R1] each trigger type keeps own enable, origin, qualify
// [R2] acquisition begin trigger starts acquiring frames
// [R3] acquisition stop trigger ends running acquisition
// [R4] acquisition window trigger: acquire while active
// [R5] frame begin trigger captures exactly one frame
// [R6] frame stop trigger ends current frame
// [R7] frame window trigger: frame lasts while active
// [R8] burst begin; length from setting unless stop enabled
// [R9] several frames style caps total frame count
// [R10] burst stop trigger ends current burst
// [R11] burst window trigger: burst lasts while active
// [R12] row begin trigger starts one line capture
// [R13] exposure begin, stop and window control exposure
// [R14] disabled trigger type is ignored
// [R15] software command gives one event for type
// [R16] origin acts only when type is enabled
// [R17] software pulse origin routes matching pulse command
// [R18] input pin origin routes synchronised pin
// [R19] counter, timer, encoder, user, broadcast origins
// [R20] transport trigger origin routes link trigger
// [R21] four cable control lines, each synchronised
// [R22] edge qualify: rise, fall or either
// [R23] level qualify: valid while high or low
// [R24] external lines pass two flop synchroniser
`ifndef CTSA_CONSTS_SVH
`define CTSA_CONSTS_SVH
`define CTSA_OFF_SEL      8'h00
`define CTSA_OFF_CFG      8'h04
`define CTSA_OFF_SWTRIG   8'h08
`define CTSA_OFF_SWPULSE  8'h0c
`define CTSA_OFF_STYLE    8'h10
`define CTSA_OFF_ACQCMD   8'h14
`define CTSA_OFF_BURST    8'h18
`define CTSA_OFF_TOTAL    8'h1c
`define CTSA_OFF_STATUS   8'h20
`define CTSA_OFF_COUNT    8'h24
`define CTSA_CFG_EN_BIT   0
`define CTSA_CFG_Q_LSB    4
`define CTSA_CFG_O_LSB    8
`define CTSA_NTYPES       13
`define CTSA_G_SOFT       4'h0
`define CTSA_G_SWPULSE    4'h1
`define CTSA_G_LINE       4'h2
`define CTSA_G_CNT_BEGIN  4'h3
`define CTSA_G_CNT_STOP   4'h4
`define CTSA_G_TMR_BEGIN  4'h5
`define CTSA_G_TMR_STOP   4'h6
`define CTSA_G_SHAFT      4'h7
`define CTSA_G_USER       4'h8
`define CTSA_G_BCAST      4'h9
`define CTSA_G_TRANSPORT  4'ha
`define CTSA_G_CABLE      4'hb
`define CTSA_RST_BURST    16'h0001
`define CTSA_RST_TOTAL    16'h0001
`define CTSA_FRAME_CYC    16
`endif

// ### core/ctsa_pkg.sv
// types of the trigger select and activation block
package ctsa_pkg;
    typedef enum logic [3:0] {
        CTSA_ACQ_BEGIN   = 4'h0,
        CTSA_ACQ_STOP    = 4'h1,
        CTSA_ACQ_WIN     = 4'h2,
        CTSA_FRM_BEGIN   = 4'h3,
        CTSA_FRM_STOP    = 4'h4,
        CTSA_FRM_WIN     = 4'h5,
        CTSA_BST_BEGIN   = 4'h6,
        CTSA_BST_STOP    = 4'h7,
        CTSA_BST_WIN     = 4'h8,
        CTSA_ROW_BEGIN   = 4'h9,
        CTSA_EXPO_BEGIN  = 4'ha,
        CTSA_EXPO_STOP   = 4'hb,
        CTSA_EXPO_WIN    = 4'hc
    } ctsa_type_t;
    typedef enum logic [2:0] {
        CTSA_Q_RISE      = 3'h0,
        CTSA_Q_FALL      = 3'h1,
        CTSA_Q_EITHER    = 3'h2,
        CTSA_Q_HIGH      = 3'h3,
        CTSA_Q_LOW       = 3'h4
    } ctsa_qual_t;
    typedef enum logic [1:0] {
        CTSA_S_SINGLE    = 2'h0,
        CTSA_S_SEVERAL   = 2'h1,
        CTSA_S_CONT      = 2'h2
    } ctsa_style_t;
    typedef struct packed {
        logic        en;
        logic [2:0]  qual;
        logic [7:0]  origin;
    } ctsa_cfg_t;
    typedef struct packed {
        logic [3:0]  sw_pulse;
        logic [3:0]  line;
        logic [3:0]  cnt_begin;
        logic [3:0]  cnt_stop;
        logic [3:0]  tmr_begin;
        logic [3:0]  tmr_stop;
        logic [3:0]  shaft;
        logic [3:0]  user;
        logic [3:0]  bcast;
        logic [3:0]  transport;
        logic [3:0]  cable;
    } ctsa_src_t;
endpackage

// ### core/ctsa_top.sv
// trigger select, source routing, qualification and acquisition sequencing
`include "ctsa_consts.svh"
module ctsa_top
    import ctsa_pkg::*;
#(
    parameter int FRAME_CYC = `CTSA_FRAME_CYC
) (
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        rstn,
    // apb slave
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [7:0]  paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    // external lines
    input  wire logic [3:0]  input_pin_origin_n,
    input  wire logic [3:0]  cable_ctrl_line_n,
    // internal sources
    input  wire logic [3:0]  cnt_begin_origin_n,
    input  wire logic [3:0]  cnt_stop_origin_n,
    input  wire logic [3:0]  tmr_begin_origin_n,
    input  wire logic [3:0]  tmr_stop_origin_n,
    input  wire logic [3:0]  shaft_pos_origin_n,
    input  wire logic [3:0]  user_bit_origin_n,
    input  wire logic [3:0]  bcast_cmd_origin_n,
    input  wire logic [3:0]  transport_trig_origin_n,
    // acquisition status
    output logic             acq_active,
    output logic             burst_active,
    output logic             frame_active,
    output logic             expo_active,
    output logic             row_pulse
);
    localparam int NT = `CTSA_NTYPES;

    typedef struct packed {
        logic [3:0]          sel;
        ctsa_cfg_t [NT-1:0]  cfg;
        logic [1:0]          style;
        logic [15:0]         burst_len;
        logic [15:0]         total;
        logic [3:0]          ls1;
        logic [3:0]          ls2;
        logic [3:0]          cs1;
        logic [3:0]          cs2;
        logic [NT-1:0]       prev;
        logic [NT-1:0]       swcmd;
        logic [3:0]          swpulse;
        logic                acq;
        logic                burst;
        logic                frame;
        logic                expo;
        logic                row;
        logic [15:0]         frm_cnt;
        logic [15:0]         bst_cnt;
        logic [15:0]         dur;
        logic                pready;
        logic                pslverr;
        logic [31:0]         prdata;
    } ctsa_st_t;

    ctsa_st_t s_q;
    ctsa_st_t s_d;
    logic     rs1_q;
    logic     rs2_q;
    logic     rst_n;

    // two flop release of the asynchronous reset
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            rs1_q <= 1'b0;
            rs2_q <= 1'b0;
        end else begin
            rs1_q <= 1'b1;
            rs2_q <= rs1_q;
        end
    end
    assign rst_n = rs2_q;

    // pick one bit of the chosen origin group
    function automatic logic origin_val(input logic [7:0] o,
                                        input ctsa_src_t v,
                                        input logic sw);
        logic [3:0] g;
        g = 4'h0;
        unique case (o[7:4])
            `CTSA_G_SWPULSE:   g = v.sw_pulse;
            `CTSA_G_LINE:      g = v.line;
            `CTSA_G_CNT_BEGIN: g = v.cnt_begin;
            `CTSA_G_CNT_STOP:  g = v.cnt_stop;
            `CTSA_G_TMR_BEGIN: g = v.tmr_begin;
            `CTSA_G_TMR_STOP:  g = v.tmr_stop;
            `CTSA_G_SHAFT:     g = v.shaft;
            `CTSA_G_USER:      g = v.user;
            `CTSA_G_BCAST:     g = v.bcast;
            `CTSA_G_TRANSPORT: g = v.transport;
            `CTSA_G_CABLE:     g = v.cable;
            default:           g = 4'h0;
        endcase
        if (o[7:4] == `CTSA_G_SOFT) begin
            return sw;
        end
        return (o[3:2] == 2'b00) ? g[o[1:0]] : 1'b0;
    endfunction

    // edge or level qualification of a source
    function automatic logic qualify(input logic p, input logic c,
                                     input logic [2:0] q);
        unique case (q)
            CTSA_Q_RISE:   return c & ~p;
            CTSA_Q_FALL:   return ~c & p;
            CTSA_Q_EITHER: return c ^ p;
            CTSA_Q_HIGH:   return c;
            CTSA_Q_LOW:    return ~c;
            default:       return 1'b0;
        endcase
    endfunction

    ctsa_src_t     src;
    logic [NT-1:0] cur;
    logic [NT-1:0] evt;
    logic [NT-1:0] lvl;
    logic [NT-1:0] en;
    logic          wr;
    logic          rd;
    logic          frm_start;
    logic          frm_stop;
    logic          frm_done;
    logic          lim;
    logic          burst_used;
    logic          acq_go;
    logic          acq_end;
    logic [15:0]   fc_inc;
    logic [15:0]   bc_inc;

    always_comb begin
        s_d = s_q;
        s_d.pready = 1'b0;
        s_d.pslverr = 1'b0;
        s_d.swcmd = '0;
        s_d.swpulse = '0;
        s_d.ls1 = input_pin_origin_n;      // [R24]
        s_d.ls2 = s_q.ls1;                 // [R24]
        s_d.cs1 = cable_ctrl_line_n;       // [R21]
        s_d.cs2 = s_q.cs1;                 // [R21]
        src.sw_pulse = s_q.swpulse;        // [R17]
        src.line = s_q.ls2;                // [R18]
        src.cnt_begin = cnt_begin_origin_n; // [R19]
        src.cnt_stop = cnt_stop_origin_n;
        src.tmr_begin = tmr_begin_origin_n;
        src.tmr_stop = tmr_stop_origin_n;
        src.shaft = shaft_pos_origin_n;
        src.user = user_bit_origin_n;
        src.bcast = bcast_cmd_origin_n;
        src.transport = transport_trig_origin_n; // [R20]
        src.cable = s_q.cs2;
        for (int t = 0; t < NT; t++) begin
            en[t] = s_q.cfg[t].en;
            cur[t] = origin_val(s_q.cfg[t].origin, src, s_q.swcmd[t]);
            s_d.prev[t] = cur[t];
            // software origins are already one cycle events
            if (s_q.cfg[t].origin[7:4] <= `CTSA_G_SWPULSE) begin
                evt[t] = en[t] & cur[t];   // [R15] [R16]
                lvl[t] = en[t] & cur[t];
            end else begin
                evt[t] = en[t] & qualify(s_q.prev[t], cur[t],
                                         s_q.cfg[t].qual); // [R14] [R22] [R23]
                lvl[t] = en[t] & ((s_q.cfg[t].qual == CTSA_Q_FALL ||
                                   s_q.cfg[t].qual == CTSA_Q_LOW)
                                  ? ~cur[t] : cur[t]); // [R23]
            end
        end

        // frame sequencing
        burst_used = en[CTSA_BST_BEGIN] | en[CTSA_BST_WIN];
        fc_inc = s_q.frm_cnt + 16'h0001;
        bc_inc = s_q.bst_cnt + 16'h0001;
        frm_start = 1'b0;
        frm_stop = 1'b0;
        if (!s_q.frame && s_q.acq && (!burst_used || s_q.burst)) begin
            if (en[CTSA_FRM_WIN]) begin
                frm_start = lvl[CTSA_FRM_WIN];        // [R7]
            end else if (en[CTSA_FRM_BEGIN]) begin
                frm_start = evt[CTSA_FRM_BEGIN];      // [R5]
            end else begin
                frm_start = 1'b1;
            end
        end
        if (s_q.frame) begin
            if (en[CTSA_FRM_WIN]) begin
                frm_stop = ~lvl[CTSA_FRM_WIN];        // [R7]
            end else if (en[CTSA_FRM_STOP]) begin
                frm_stop = evt[CTSA_FRM_STOP];        // [R6]
            end else begin
                frm_stop = (s_q.dur == 16'(FRAME_CYC - 1)); // [R5]
            end
        end
        frm_done = s_q.frame & frm_stop;
        if (frm_start) begin
            s_d.frame = 1'b1;
            s_d.dur = '0;
        end else if (frm_done) begin
            s_d.frame = 1'b0;
            s_d.frm_cnt = fc_inc;
            s_d.bst_cnt = bc_inc;
        end else if (s_q.frame) begin
            s_d.dur = s_q.dur + 16'h0001;
        end
        unique case (s_q.style)
            CTSA_S_SINGLE:  lim = frm_done;
            CTSA_S_SEVERAL: lim = frm_done & (fc_inc >= s_q.total); // [R9]
            default:        lim = 1'b0;
        endcase

        // burst sequencing
        if (en[CTSA_BST_WIN]) begin
            s_d.burst = lvl[CTSA_BST_WIN] & s_q.acq;  // [R11]
            if (!s_q.burst) begin
                s_d.bst_cnt = '0;
            end
        end else if (!s_q.burst) begin
            if (s_q.acq && evt[CTSA_BST_BEGIN]) begin
                s_d.burst = 1'b1;                      // [R8]
                s_d.bst_cnt = '0;
            end
        end else if (!s_q.acq) begin
            s_d.burst = 1'b0;
        end else if (en[CTSA_BST_STOP]) begin
            if (evt[CTSA_BST_STOP]) begin
                s_d.burst = 1'b0;                      // [R10]
            end
        end else if (frm_done && bc_inc >= s_q.burst_len) begin
            s_d.burst = 1'b0;                          // [R8]
        end

        // acquisition sequencing
        wr = psel & penable & pwrite & ~s_q.pready;
        rd = psel & penable & ~pwrite & ~s_q.pready;
        acq_go = en[CTSA_ACQ_BEGIN] ? evt[CTSA_ACQ_BEGIN]
               : (wr && paddr == `CTSA_OFF_ACQCMD && pwdata[0]);
        acq_end = evt[CTSA_ACQ_STOP] | lim |
                  (wr && paddr == `CTSA_OFF_ACQCMD && pwdata[1]);
        if (en[CTSA_ACQ_WIN]) begin
            s_d.acq = lvl[CTSA_ACQ_WIN] & ~lim;       // [R4]
            if (!s_q.acq) begin
                s_d.frm_cnt = '0;
            end
        end else if (!s_q.acq && acq_go) begin
            s_d.acq = 1'b1;                            // [R2]
            s_d.frm_cnt = '0;
        end else if (s_q.acq && acq_end) begin
            s_d.acq = 1'b0;                            // [R3] [R9]
        end
        if (!s_d.acq) begin
            s_d.frame = 1'b0;
        end

        // row and exposure
        s_d.row = evt[CTSA_ROW_BEGIN] & s_q.frame;    // [R12]
        if (en[CTSA_EXPO_WIN]) begin
            s_d.expo = lvl[CTSA_EXPO_WIN] & s_q.frame; // [R13]
        end else if (en[CTSA_EXPO_BEGIN] | en[CTSA_EXPO_STOP]) begin
            if (!s_q.frame || evt[CTSA_EXPO_STOP]) begin
                s_d.expo = 1'b0;                       // [R13]
            end else if (evt[CTSA_EXPO_BEGIN]) begin
                s_d.expo = 1'b1;
            end
        end else begin
            s_d.expo = s_d.frame;
        end

        // register access, answered one cycle into the access phase
        if (wr | rd) begin
            s_d.pready = 1'b1;
            s_d.prdata = '0;
        end
        if (wr) begin
            unique case (paddr)
                `CTSA_OFF_SEL: begin
                    if (pwdata[3:0] < 4'(NT)) begin
                        s_d.sel = pwdata[3:0];         // [R1]
                    end
                end
                `CTSA_OFF_CFG: begin
                    s_d.cfg[s_q.sel].en = pwdata[`CTSA_CFG_EN_BIT]; // [R1]
                    s_d.cfg[s_q.sel].qual = pwdata[`CTSA_CFG_Q_LSB +: 3];
                    s_d.cfg[s_q.sel].origin = pwdata[`CTSA_CFG_O_LSB +: 8];
                end
                `CTSA_OFF_SWTRIG:  s_d.swcmd[s_q.sel] = pwdata[0]; // [R15]
                `CTSA_OFF_SWPULSE: s_d.swpulse = pwdata[3:0]; // [R17]
                `CTSA_OFF_STYLE:   s_d.style = pwdata[1:0];
                `CTSA_OFF_ACQCMD:  s_d.pslverr = 1'b0;
                `CTSA_OFF_BURST:   s_d.burst_len = pwdata[15:0];
                `CTSA_OFF_TOTAL:   s_d.total = pwdata[15:0];
                default:           s_d.pslverr = 1'b1;
            endcase
        end
        if (rd) begin
            unique case (paddr)
                `CTSA_OFF_SEL:    s_d.prdata = {28'h0, s_q.sel};
                `CTSA_OFF_CFG:    s_d.prdata = {16'h0, s_q.cfg[s_q.sel].origin,
                                                1'b0, s_q.cfg[s_q.sel].qual,
                                                3'h0, s_q.cfg[s_q.sel].en};
                `CTSA_OFF_STYLE:  s_d.prdata = {30'h0, s_q.style};
                `CTSA_OFF_BURST:  s_d.prdata = {16'h0, s_q.burst_len};
                `CTSA_OFF_TOTAL:  s_d.prdata = {16'h0, s_q.total};
                `CTSA_OFF_STATUS: s_d.prdata = {27'h0, s_q.row, s_q.expo,
                                                s_q.frame, s_q.burst, s_q.acq};
                `CTSA_OFF_COUNT:  s_d.prdata = {16'h0, s_q.frm_cnt};
                `CTSA_OFF_SWTRIG, `CTSA_OFF_SWPULSE,
                `CTSA_OFF_ACQCMD: s_d.prdata = '0;
                default:          s_d.pslverr = 1'b1;
            endcase
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n) begin
        if (!rst_n) begin
            s_q <= '0;
            s_q.burst_len <= `CTSA_RST_BURST;
            s_q.total <= `CTSA_RST_TOTAL;
        end else begin
            s_q <= s_d;
        end
    end

    assign prdata = s_q.prdata;
    assign pready = s_q.pready;
    assign pslverr = s_q.pslverr;
    assign acq_active = s_q.acq;
    assign burst_active = s_q.burst;
    assign frame_active = s_q.frame;
    assign expo_active = s_q.expo;
    assign row_pulse = s_q.row;

    sequence s_frame_ends;
        s_q.acq && frm_done;
    endsequence
    property p_sync;
        @(posedge sys_clk) disable iff (!rst_n)
        $past(input_pin_origin_n, 2) == s_q.ls2;
    endproperty
    a_sync: assert property (p_sync) else $error("line sync depth wrong"); // [R24]
    property p_acq_go;
        @(posedge sys_clk) disable iff (!rst_n)
        !s_q.acq && !en[CTSA_ACQ_WIN] && en[CTSA_ACQ_BEGIN] &&
        evt[CTSA_ACQ_BEGIN] |=> s_q.acq && s_q.frm_cnt == 16'h0;
    endproperty
    a_acq_go: assert property (p_acq_go) else $error("acq did not start"); // [R2]
    property p_acq_end;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.acq && !en[CTSA_ACQ_WIN] && evt[CTSA_ACQ_STOP] |=> !s_q.acq;
    endproperty
    a_acq_end: assert property (p_acq_end) else $error("acq did not stop"); // [R3]
    property p_off;
        @(posedge sys_clk) disable iff (!rst_n)
        !s_q.acq && !en[CTSA_ACQ_BEGIN] && !en[CTSA_ACQ_WIN] && !wr |=> !s_q.acq;
    endproperty
    a_off: assert property (p_off) else $error("disabled trigger acted"); // [R14]
    property p_one_frame;
        @(posedge sys_clk) disable iff (!rst_n)
        s_frame_ends |=> s_q.frm_cnt == $past(s_q.frm_cnt) + 16'h1;
    endproperty
    a_one_frame: assert property (p_one_frame) else $error("frame count bad"); // [R5]
    property p_fwin;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.frame && en[CTSA_FRM_WIN] && !lvl[CTSA_FRM_WIN] |=> !s_q.frame;
    endproperty
    a_fwin: assert property (p_fwin) else $error("frame outlived window"); // [R7]
    property p_total;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.acq && s_q.style == CTSA_S_SEVERAL && frm_done &&
        fc_inc >= s_q.total |=> !s_q.acq;
    endproperty
    a_total: assert property (p_total) else $error("total frames exceeded"); // [R9]
    property p_burst_len;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.burst && s_q.acq && !en[CTSA_BST_STOP] && !en[CTSA_BST_WIN] &&
        frm_done && bc_inc >= s_q.burst_len |=> !s_q.burst;
    endproperty
    a_burst_len: assert property (p_burst_len) else $error("burst too long"); // [R8]
    property p_row;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.frame && evt[CTSA_ROW_BEGIN] |=> s_q.row;
    endproperty
    a_row: assert property (p_row) else $error("row pulse missing"); // [R12]
    property p_expo;
        @(posedge sys_clk) disable iff (!rst_n)
        s_q.frame && !en[CTSA_EXPO_WIN] && evt[CTSA_EXPO_BEGIN] &&
        !evt[CTSA_EXPO_STOP] |=> s_q.expo || !s_q.frame;
    endproperty
    a_expo: assert property (p_expo) else $error("exposure did not start"); // [R13]
endmodule // ctsa_top

// ### bench/ctsa_line_model.sv
// driver model for the external trigger pins and cable control lines
module ctsa_line_model (
    // clock
    input  wire logic       sys_clk,
    // wanted levels from the bench
    input  wire logic [3:0] pin_want,
    input  wire logic [3:0] cbl_want,
    input  wire logic       slow,
    // lines into the device
    output logic      [3:0] input_pin_origin_n,
    output logic      [3:0] cable_ctrl_line_n
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] dly_q;
    initial begin
        dly_q = 8'h00;
        input_pin_origin_n = 4'h0;
        cable_ctrl_line_n = 4'h0;
    end
    // slow lines lag one more cycle, like a filtered long cable
    always @(posedge sys_clk) begin
        dly_q <= {cbl_want, pin_want};
        {cable_ctrl_line_n, input_pin_origin_n} <= slow ? dly_q : {cbl_want, pin_want};
    end
endmodule // ctsa_line_model

// ### bench/ctsa_top_tb.sv
// self-checking bench for the trigger select and activation block
`include "ctsa_consts.svh"
module ctsa_top_tb
    import ctsa_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ns;
    localparam int FC = 4;
    logic        sys_clk, rstn, psel, penable, pwrite, pready, pslverr, slv, slow;
    logic [7:0]  paddr;
    logic [31:0] pwdata, prdata, src, rd;
    logic [3:0]  pin_want, cbl_want, pins, cbls;
    logic        acq_active, burst_active, frame_active, expo_active, row_pulse;
    logic [4:0]  st;
    int          errors, n_compared, q;
    assign st = {row_pulse, expo_active, frame_active, burst_active, acq_active};

    ctsa_top #(.FRAME_CYC(FC)) i_dut (
        .sys_clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .input_pin_origin_n(pins), .cable_ctrl_line_n(cbls),
        .cnt_begin_origin_n(src[3:0]), .cnt_stop_origin_n(src[7:4]),
        .tmr_begin_origin_n(src[11:8]), .tmr_stop_origin_n(src[15:12]),
        .shaft_pos_origin_n(src[19:16]), .user_bit_origin_n(src[23:20]),
        .bcast_cmd_origin_n(src[27:24]), .transport_trig_origin_n(src[31:28]),
        .acq_active, .burst_active, .frame_active, .expo_active, .row_pulse
    );
    ctsa_line_model i_lines (
        .sys_clk, .pin_want, .cbl_want, .slow,
        .input_pin_origin_n(pins), .cable_ctrl_line_n(cbls)
    );

    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic close_out();
        $display("compared %0d mismatches %0d", n_compared, errors);
        if (errors == 0 && n_compared > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            errors++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic chkb(input logic got, input logic exp);
        chk({31'h0, got}, {31'h0, exp});
    endtask
    // master holds the request until pready is seen at an edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
        end while (pready !== 1'b1);
        rd = prdata;
        slv = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(rd, exp);
    endtask
    task automatic cfg(input logic [3:0] t, input logic [31:0] c);
        wr(`CTSA_OFF_SEL, {28'h0, t});
        wr(`CTSA_OFF_CFG, c);
    endtask
    task automatic swt(input logic [3:0] t);
        wr(`CTSA_OFF_SEL, {28'h0, t});
        wr(`CTSA_OFF_SWTRIG, 32'h1);
    endtask
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk);
        #1;
    endtask
    task automatic drive(input int b, input logic v);
        @(posedge sys_clk);
        src[b] <= v;
    endtask
    // bounded wait on one status output, then compare it
    task automatic wait_st(input int b, input logic v);
        int n;
        n = 0;
        while (st[b] !== v && n < 300) begin
            cyc(1);
            n++;
        end
        chkb(st[b], v);
    endtask
    // a stalled run counts as a mismatch
    initial begin
        repeat (20000) @(posedge sys_clk);
        errors++;
        close_out();
    end

    initial begin
        {rstn, psel, penable, pwrite, slow} = 5'h0;
        {paddr, pwdata, src, pin_want, cbl_want} = '0;
        errors = 0;
        n_compared = 0;
        repeat (10) @(posedge sys_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge sys_clk);
        rdc(`CTSA_OFF_BURST, 32'h1);
        rdc(`CTSA_OFF_TOTAL, 32'h1);
        rdc(`CTSA_OFF_STATUS, 32'h0);
        rdc(8'h40, 32'h0);
        chkb(slv, 1'b1);
        cfg(4'hc, 32'h0b30);
        cfg(4'hb, 32'h7240);
        wr(`CTSA_OFF_SEL, 32'hc);
        wr(`CTSA_OFF_SEL, 32'hd);
        rdc(`CTSA_OFF_CFG, 32'h0b30);
        $display("test registers done");
        cfg(4'h0, 32'h0);
        swt(4'h0);
        cyc(3);
        chkb(acq_active, 1'b0);
        wr(`CTSA_OFF_STYLE, 32'h2);
        cfg(4'h1, 32'h1);
        // each internal group once, edge kinds in turn
        for (int g = 3; g <= 10; g++) begin
            q = g % 3;
            cfg(4'h0, 32'(1 + (q << 4) + (g << 12) + ((g % 4) << 8)));
            drive((g - 3) * 4 + g % 4, 1'b1);
            cyc(3);
            chkb(acq_active, q != 1);
            swt(4'h1);
            drive((g - 3) * 4 + g % 4, 1'b0);
            cyc(3);
            chkb(acq_active, q != 0);
            swt(4'h1);
        end
        $display("test edges done");
        cfg(4'h0, 32'h0);
        for (int k = 0; k < 4; k++) begin
            cfg(4'h2, k[1] ? 32'(32'hb301 + (k[0] ? 32'h40 : 32'h30)) :
                             32'(32'h2001 + (k[0] ? 32'h40 : 32'h30)));
            @(posedge sys_clk);
            pin_want <= 4'h1;
            cbl_want <= 4'h8;
            slow <= k[1];
            cyc(6);
            chkb(acq_active, !k[0]);
            @(posedge sys_clk);
            pin_want <= 4'he;
            cbl_want <= 4'h7;
            cyc(6);
            chkb(acq_active, k[0]);
        end
        cfg(4'h2, 32'h0);
        wr(`CTSA_OFF_ACQCMD, 32'h2);
        $display("test levels done");
        cfg(4'h3, 32'h1201);
        wr(`CTSA_OFF_ACQCMD, 32'h1);
        wr(`CTSA_OFF_SWPULSE, 32'h2);
        cyc(4);
        chkb(frame_active, 1'b0);
        wr(`CTSA_OFF_SWPULSE, 32'h4);
        wait_st(2, 1'b1);
        chkb(expo_active, 1'b1);
        wait_st(2, 1'b0);
        cyc(2 * FC);
        chkb(frame_active, 1'b0);
        rdc(`CTSA_OFF_COUNT, 32'h1);
        cfg(4'h3, 32'h0);
        wr(`CTSA_OFF_ACQCMD, 32'h2);
        $display("test frame done");
        wr(`CTSA_OFF_STYLE, 32'h1);
        wr(`CTSA_OFF_BURST, 32'h2);
        wr(`CTSA_OFF_TOTAL, 32'h3);
        cfg(4'h6, 32'h1);
        wr(`CTSA_OFF_ACQCMD, 32'h1);
        cyc(2 * FC);
        chkb(frame_active, 1'b0);
        swt(4'h6);
        wait_st(1, 1'b1);
        wait_st(1, 1'b0);
        rdc(`CTSA_OFF_COUNT, 32'h2);
        chkb(acq_active, 1'b1);
        swt(4'h6);
        wait_st(0, 1'b0);
        rdc(`CTSA_OFF_COUNT, 32'h3);
        $display("test burst done");
        // frame window on shaft 0, row on shaft 1, exposure on shaft 2 edges
        cfg(4'h6, 32'h0);
        cfg(4'h5, 32'h7031);
        cfg(4'h9, 32'h7101);
        cfg(4'ha, 32'h7201);
        cfg(4'hb, 32'h7211);
        wr(`CTSA_OFF_ACQCMD, 32'h1);
        drive(16, 1'b1);
        cyc(2);
        chkb(frame_active, 1'b1);
        drive(17, 1'b1);
        cyc(1);
        chkb(row_pulse, 1'b1);
        cyc(1);
        chkb(row_pulse, 1'b0);
        drive(18, 1'b1);
        cyc(1);
        chkb(expo_active, 1'b1);
        drive(18, 1'b0);
        cyc(1);
        chkb(expo_active, 1'b0);
        chkb(frame_active, 1'b1);
        drive(16, 1'b0);
        cyc(1);
        chkb(frame_active, 1'b0);
        rdc(`CTSA_OFF_COUNT, 32'h1);
        $display("test windows done");
        close_out();
    end
endmodule // ctsa_top_tb
